// ---- sdr_pkg.sv ----
// Constants and types for the processor status and debug register bank
package sdr_pkg;
  localparam logic [7:0] SDR_OFF_OSC_CTRL  = 8'h06;
  localparam logic [7:0] SDR_OFF_TC_CNT    = 8'h07;
  localparam logic [7:0] SDR_OFF_TW_CNT    = 8'h08;
  localparam logic [7:0] SDR_OFF_PC_CNT    = 8'h09;
  localparam logic [7:0] SDR_OFF_PW_CNT    = 8'h0a;
  localparam logic [7:0] SDR_OFF_RAM_SIZE  = 8'h0c;
  localparam logic [7:0] SDR_OFF_SSR       = 8'h10;
  localparam logic [7:0] SDR_OFF_SPC       = 8'h11;
  localparam logic [7:0] SDR_OFF_SSP       = 8'h12;
  localparam logic [7:0] SDR_OFF_THR_SEL   = 8'h13;
  localparam logic [7:0] SDR_OFF_REG_SEL   = 8'h14;
  localparam logic [7:0] SDR_OFF_CAUSE     = 8'h15;
  localparam logic [7:0] SDR_OFF_INFO      = 8'h16;
  localparam logic [7:0] SDR_OFF_STOP      = 8'h18;
  localparam int SDR_CTRL_CORE_BIT  = 1;
  localparam int SDR_CTRL_PERI_BIT  = 0;
  localparam int SDR_CNT_W          = 16;
  localparam int SDR_ISSUE_CUR_BIT  = 8;
  // Writable saved-status bits: 0..4, 6, 7, 9, 10
  localparam logic [31:0] SDR_SSR_WMASK = 32'h0000_06df;
  localparam logic [31:0] SDR_SSR_MASK  = 32'h0000_07df;
  localparam logic [31:0] SDR_CAUSE_MASK = 32'h0003_ff07;
  localparam logic [2:0] SDR_CAUSE_NONE  = 3'h0;
  localparam logic [2:0] SDR_CAUSE_HOST  = 3'h1;
  localparam logic [2:0] SDR_CAUSE_DEBUG_CALL_INSTR = 3'h2;
  localparam logic [2:0] SDR_CAUSE_IBRK  = 3'h3;
  localparam logic [2:0] SDR_CAUSE_DWP   = 3'h4;
  localparam logic [2:0] SDR_CAUSE_RWP   = 3'h5;
  localparam int SDR_OSC_STOP_NS = 400;
  localparam int SDR_CLK_NS      = 40;
  localparam int SDR_OSC_STOP_CYC = (SDR_OSC_STOP_NS + SDR_CLK_NS - 1) / SDR_CLK_NS;
  typedef struct packed {
    logic        valid;
    logic [2:0]  cause;
    logic [7:0]  thread;
    logic [3:0]  hit;
    logic [31:0] status;
    logic [31:0] pc;
    logic [31:0] sp;
    logic [31:0] info;
  } sdr_entry_t;
  typedef struct packed {
    logic [7:0] thread;
    logic [4:0] regnum;
  } sdr_rdsel_t;
endpackage

// ---- sdr_status_debug_regs.sv ----
// Status, ring oscillator and debug register bank of one tile
`timescale 1ns/1ns
module sdr_status_debug_regs #(
  parameter int          RAM_BYTES = 32'h0008_0000,
  parameter int          THREADS   = 8
) (
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire logic [3:0]          osc_clk,
  input  wire logic                ps_wr,
  input  wire logic                ps_rd,
  input  wire logic [7:0]          ps_addr,
  input  wire logic [31:0]         ps_wdata,
  output logic      [31:0]         ps_rdata,
  input  wire sdr_pkg::sdr_entry_t dbg_entry,
  input  wire logic                issue_mode_flag,
  output logic      [1:0]          osc_enable,
  output sdr_pkg::sdr_rdsel_t      debug_register_read,
  output logic      [7:0]          thread_stop_mask
);
  initial begin
    if (THREADS < 1 || THREADS > 8) $error("THREADS must be 1..8");
  end

  ////////////////////////////////////////////////////////////////////
  // Control state
  logic [1:0]  osc_ctrl_reg, osc_ctrl_next;
  logic [31:0] ssr_reg, ssr_next, spc_reg, spc_next, ssp_reg, ssp_next;
  logic [31:0] cause_reg, cause_next, info_reg, info_next;
  logic [7:0]  thr_reg, thr_next, stop_reg, stop_next;
  logic [4:0]  rsel_reg, rsel_next;
  logic [1:0]  hit_num;
  logic [31:0] rdata_next;

  // Lowest triggering breakpoint wins
  always_comb begin
    hit_num = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (dbg_entry.hit[i]) begin
        hit_num = 2'(i);
      end
    end
  end

  always_comb begin
    osc_ctrl_next = osc_ctrl_reg;
    ssr_next      = ssr_reg;
    spc_next      = spc_reg;
    ssp_next      = ssp_reg;
    cause_next    = cause_reg;
    info_next     = info_reg;
    thr_next      = thr_reg;
    rsel_next     = rsel_reg;
    stop_next     = stop_reg;
    if (ps_wr) begin
      unique case (ps_addr)
        sdr_pkg::SDR_OFF_OSC_CTRL: osc_ctrl_next = ps_wdata[1:0];
        sdr_pkg::SDR_OFF_SSR:
          ssr_next = (ssr_reg & ~sdr_pkg::SDR_SSR_WMASK)
                   | (ps_wdata & sdr_pkg::SDR_SSR_WMASK);
        sdr_pkg::SDR_OFF_SPC:      spc_next = ps_wdata;
        sdr_pkg::SDR_OFF_SSP:      ssp_next = ps_wdata;
        sdr_pkg::SDR_OFF_THR_SEL:  thr_next = ps_wdata[7:0];
        sdr_pkg::SDR_OFF_REG_SEL:  rsel_next = ps_wdata[4:0];
        sdr_pkg::SDR_OFF_CAUSE:    cause_next = ps_wdata & sdr_pkg::SDR_CAUSE_MASK;
        sdr_pkg::SDR_OFF_INFO:     info_next = ps_wdata;
        sdr_pkg::SDR_OFF_STOP:     stop_next = ps_wdata[7:0];
        default: ;
      endcase
    end
    // Hardware capture beats a same-cycle software write
    if (dbg_entry.valid) begin
      ssr_next = dbg_entry.status & sdr_pkg::SDR_SSR_MASK;
      spc_next = dbg_entry.pc;
      ssp_next = dbg_entry.sp;
      cause_next = '0;
      cause_next[2:0] = dbg_entry.cause;
      if (dbg_entry.cause != sdr_pkg::SDR_CAUSE_HOST) begin
        cause_next[15:8] = dbg_entry.thread;
      end
      if (dbg_entry.cause >= sdr_pkg::SDR_CAUSE_IBRK) begin
        cause_next[17:16] = hit_num;
      end
      if (dbg_entry.cause == sdr_pkg::SDR_CAUSE_DWP ||
          dbg_entry.cause == sdr_pkg::SDR_CAUSE_RWP) begin
        info_next = dbg_entry.info;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      osc_ctrl_reg <= 2'h0;
      ssr_reg      <= 32'h0;
      spc_reg      <= 32'h0;
      ssp_reg      <= 32'h0;
      cause_reg    <= 32'h0;
      info_reg     <= 32'h0;
      thr_reg      <= 8'h0;
      rsel_reg     <= 5'h0;
      stop_reg     <= 8'h0;
    end else begin
      osc_ctrl_reg <= osc_ctrl_next;
      ssr_reg      <= ssr_next;
      spc_reg      <= spc_next;
      ssp_reg      <= ssp_next;
      cause_reg    <= cause_next;
      info_reg     <= info_next;
      thr_reg      <= thr_next;
      rsel_reg     <= rsel_next;
      stop_reg     <= stop_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Ring oscillator counters, one per oscillator clock
  // Osc 0,1 are core (tile), 2,3 peripheral
  logic [sdr_pkg::SDR_CNT_W-1:0] cnt_val [4];
  logic [sdr_pkg::SDR_CNT_W-1:0] cnt_sync [4];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_osc
      // Power-up values only; reset must not touch these, so unknowns cannot be flushed
      logic [sdr_pkg::SDR_CNT_W-1:0] cnt_reg = 16'h0000;
      logic [sdr_pkg::SDR_CNT_W-1:0] cnt_next;
      logic [2:0]                    en_sync_reg = 3'h0;
      logic [2:0]                    en_sync_next;
      logic                          en_now;
      logic [sdr_pkg::SDR_CNT_W-1:0] s1_reg = 16'h0000;
      logic [sdr_pkg::SDR_CNT_W-1:0] s2_reg = 16'h0000;
      logic [sdr_pkg::SDR_CNT_W-1:0] s3_reg = 16'h0000;
      logic [sdr_pkg::SDR_CNT_W-1:0] smp_reg = 16'h0000;
      logic [sdr_pkg::SDR_CNT_W-1:0] smp_next;
      assign en_now = (g < 2) ? osc_ctrl_reg[sdr_pkg::SDR_CTRL_CORE_BIT]
                              : osc_ctrl_reg[sdr_pkg::SDR_CTRL_PERI_BIT];
      always_comb begin
        en_sync_next = {en_sync_reg[1:0], en_now};
        cnt_next = cnt_reg;
        if (en_sync_reg[2] && en_sync_reg[1]) begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      // No reset: count survives system reset and is random anyway
      always_ff @(posedge osc_clk[g]) begin
        en_sync_reg <= en_sync_next;
        cnt_reg     <= cnt_next;
      end
      // Value is only stable once the oscillator is stopped
      always_comb begin
        smp_next = smp_reg;
        if (s2_reg == s3_reg) begin
          smp_next = s3_reg;
        end
      end
      always_ff @(posedge clk_sys) begin
        s1_reg  <= cnt_reg;
        s2_reg  <= s1_reg;
        s3_reg  <= s2_reg;
        smp_reg <= smp_next;
      end
      assign cnt_val[g]  = cnt_reg;
      assign cnt_sync[g] = smp_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    rdata_next = 32'h0;
    unique case (ps_addr)
      sdr_pkg::SDR_OFF_OSC_CTRL: rdata_next = {30'h0, osc_ctrl_reg};
      sdr_pkg::SDR_OFF_TC_CNT:   rdata_next = {16'h0, cnt_sync[0]};
      sdr_pkg::SDR_OFF_TW_CNT:   rdata_next = {16'h0, cnt_sync[1]};
      sdr_pkg::SDR_OFF_PC_CNT:   rdata_next = {16'h0, cnt_sync[2]};
      sdr_pkg::SDR_OFF_PW_CNT:   rdata_next = {16'h0, cnt_sync[3]};
      sdr_pkg::SDR_OFF_RAM_SIZE: rdata_next = RAM_BYTES & 32'hffff_fffc;
      sdr_pkg::SDR_OFF_SSR: begin
        rdata_next = ssr_reg;
        rdata_next[sdr_pkg::SDR_ISSUE_CUR_BIT] = issue_mode_flag;
      end
      sdr_pkg::SDR_OFF_SPC:      rdata_next = spc_reg;
      sdr_pkg::SDR_OFF_SSP:      rdata_next = ssp_reg;
      sdr_pkg::SDR_OFF_THR_SEL:  rdata_next = {24'h0, thr_reg};
      sdr_pkg::SDR_OFF_REG_SEL:  rdata_next = {27'h0, rsel_reg};
      sdr_pkg::SDR_OFF_CAUSE:    rdata_next = cause_reg;
      sdr_pkg::SDR_OFF_INFO:     rdata_next = info_reg;
      sdr_pkg::SDR_OFF_STOP:     rdata_next = {24'h0, stop_reg};
      default:                   rdata_next = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ps_rdata <= 32'h0;
    end else if (ps_rd) begin
      ps_rdata <= rdata_next;
    end
  end

  assign osc_enable          = osc_ctrl_reg;
  assign debug_register_read = '{thread: thr_reg, regnum: rsel_reg};
  assign thread_stop_mask    = stop_reg;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  ctrl_write_a: assert property (ps_wr && ps_addr == sdr_pkg::SDR_OFF_OSC_CTRL
    |=> osc_enable == $past(ps_wdata[1:0])) else $error("osc control not written");
  ssr_capture_a: assert property (dbg_entry.valid |=>
    ssr_reg == ($past(dbg_entry.status) & sdr_pkg::SDR_SSR_MASK)) else $error("ssr");
  pc_capture_a: assert property (dbg_entry.valid |=> spc_reg == $past(dbg_entry.pc))
    else $error("pc capture");
  sp_capture_a: assert property (dbg_entry.valid |=> ssp_reg == $past(dbg_entry.sp))
    else $error("sp capture");
  cause_code_a: assert property (dbg_entry.valid |=> cause_reg[2:0] == $past(dbg_entry.cause))
    else $error("cause code");
  host_thread_a: assert property (dbg_entry.valid && dbg_entry.cause == sdr_pkg::SDR_CAUSE_HOST
    |=> cause_reg[17:8] == 10'h0) else $error("host cause not zero");
  lowest_hit_a: assert property (dbg_entry.valid && dbg_entry.cause == sdr_pkg::SDR_CAUSE_IBRK
    && dbg_entry.hit[0] |=> cause_reg[17:16] == 2'h0) else $error("hit order");
  stop_mask_a: assert property (ps_wr && ps_addr == sdr_pkg::SDR_OFF_STOP && !dbg_entry.valid
    |=> thread_stop_mask == $past(ps_wdata[7:0])) else $error("stop mask");
  count_upper_a: assert property (ps_rd && ps_addr == sdr_pkg::SDR_OFF_TC_CNT
    |=> ps_rdata[31:16] == 16'h0) else $error("counter upper bits");
  ram_low_a: assert property (ps_rd && ps_addr == sdr_pkg::SDR_OFF_RAM_SIZE
    |=> ps_rdata[1:0] == 2'h0) else $error("ram size low bits");
  issue_ro_a: assert property (ps_rd && ps_addr == sdr_pkg::SDR_OFF_SSR
    |=> ps_rdata[8] == $past(issue_mode_flag)) else $error("issue mode bit");

  entry_c: cover property (dbg_entry.valid);
  dwp_c:   cover property (dbg_entry.valid && dbg_entry.cause == sdr_pkg::SDR_CAUSE_DWP);
  osc_c:   cover property (ps_wr && ps_addr == sdr_pkg::SDR_OFF_OSC_CTRL ##12
    ps_rd && ps_addr == sdr_pkg::SDR_OFF_TC_CNT);
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the status, oscillator and debug register bank
`timescale 1ns/1ns
module tb_top;
  logic                clk_sys = 1'b0;
  logic                sys_rst = 1'b1;
  logic [3:0]          osc_clk = 4'h0;
  logic                ps_wr = 1'b0;
  logic                ps_rd = 1'b0;
  logic [7:0]          ps_addr = 8'h00;
  logic [31:0]         ps_wdata = 32'h0;
  logic [31:0]         ps_rdata;
  sdr_pkg::sdr_entry_t dbg_entry = '0;
  logic                issue_mode_flag = 1'b0;
  logic [1:0]          osc_enable;
  sdr_pkg::sdr_rdsel_t debug_register_read;
  logic [7:0]          thread_stop_mask;
  int                  n_errors = 0;
  int                  tests_run = 0;
  int                  cycles = 0;
  logic [31:0]         mdl [int];
  logic [15:0]         cnt [4];
  logic [31:0]         v;
  logic [7:0]          regs [9] = '{8'h06, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h18};
  logic [1:0]          hn;

  sdr_status_debug_regs i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .osc_clk(osc_clk),
    .ps_wr(ps_wr), .ps_rd(ps_rd), .ps_addr(ps_addr), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata),
    .dbg_entry(dbg_entry), .issue_mode_flag(issue_mode_flag), .osc_enable(osc_enable),
    .debug_register_read(debug_register_read), .thread_stop_mask(thread_stop_mask));

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Model and checking helpers
  function automatic logic [31:0] wmask(input logic [7:0] a);
    case (a)
      8'h06: return 32'h0000_0003;
      8'h10: return 32'h0000_06df;
      8'h11, 8'h12, 8'h16: return 32'hffff_ffff;
      8'h13, 8'h18: return 32'h0000_00ff;
      8'h14: return 32'h0000_001f;
      8'h15: return 32'h0003_ff07;
      default: return 32'h0;
    endcase
  endfunction

  function automatic logic [31:0] ex(input logic [7:0] a);
    if (a >= 8'h07 && a <= 8'h0a) return {16'h0, cnt[a - 8'h07]};
    if (a == 8'h0c) return 32'h0008_0000;
    if (a == 8'h10) return mdl[a] | {23'h0, issue_mode_flag, 8'h0};
    return mdl.exists(a) ? mdl[a] : 32'h0;
  endfunction

  task automatic test_done;
    $display("counts: %0d compared, %0d mismatched", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    ps_wr = 1'b1;
    ps_addr = a;
    ps_wdata = d;
    @(negedge clk_sys);
    ps_wr = 1'b0;
    if (wmask(a) != 32'h0) mdl[a] = d & wmask(a);
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    ps_rd = 1'b1;
    ps_addr = a;
    @(negedge clk_sys);
    ps_rd = 1'b0;
    v = ps_rdata;
  endtask

  task automatic rdc(input logic [7:0] a);
    rd(a);
    chk(v, ex(a));
  endtask

  // Ring clocks only move inside this task, so counts are exact
  task automatic osc(input logic [3:0] m, input int n);
    repeat (n) begin
      #7 osc_clk = osc_clk | m;
      #6 osc_clk = osc_clk & ~m;
    end
  endtask

  task automatic do_reset;
    @(negedge clk_sys);
    sys_rst = 1'b1;
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    foreach (regs[i]) mdl[regs[i]] = 32'h0;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(47294));
    do_reset();
    foreach (regs[i]) rdc(regs[i]);
    for (int i = 0; i < 4; i++) begin
      rd(8'h07 + 8'(i));
      cnt[i] = v[15:0];
    end
    wr(8'h06, 32'hffff_fff2);
    osc(4'hf, 10);
    wr(8'h06, {$urandom} | 32'h3);
    osc(4'hf, 8);
    osc(4'h5, 4);
    wr(8'h06, 32'h0);
    osc(4'hf, 4);
    repeat (10) @(negedge clk_sys);
    // Enable sync costs 3 ring edges on start and counts 2 more after stop
    cnt[0] += 16'd21;
    cnt[1] += 16'd17;
    cnt[2] += 16'd11;
    cnt[3] += 16'd7;
    for (int i = 7; i <= 10; i++) rdc(8'(i));
    wr(8'h07, $urandom);
    do_reset();
    for (int i = 7; i <= 10; i++) rdc(8'(i));
    $display("done: oscillator control and counters");
    for (int c = 1; c <= 5; c++) begin
      issue_mode_flag = 1'($urandom);
      @(negedge clk_sys);
      dbg_entry = {1'b1, 3'(c), 8'($urandom), 4'($urandom) | 4'h8, $urandom, $urandom,
                   $urandom, $urandom};
      @(negedge clk_sys);
      dbg_entry.valid = 1'b0;
      hn = dbg_entry.hit[0] ? 2'd0 : dbg_entry.hit[1] ? 2'd1 : dbg_entry.hit[2] ? 2'd2 : 2'd3;
      mdl[8'h10] = dbg_entry.status & 32'h0000_06df;
      mdl[8'h11] = dbg_entry.pc;
      mdl[8'h12] = dbg_entry.sp;
      mdl[8'h15] = {14'h0, (c >= 3) ? hn : 2'd0, (c == 1) ? 8'h0 : dbg_entry.thread, 5'h0, 3'(c)};
      if (c >= 4) mdl[8'h16] = dbg_entry.info;
      for (int a = 8'h10; a <= 8'h16; a++) rdc(8'(a));
    end
    $display("done: debugger entry capture");
    repeat (3) begin
      foreach (regs[i]) wr(regs[i], $urandom);
      issue_mode_flag = ~issue_mode_flag;
      foreach (regs[i]) rdc(regs[i]);
      chk({30'h0, osc_enable}, mdl[8'h06]);
      chk({19'h0, debug_register_read}, {mdl[8'h13][18:0] << 5} | mdl[8'h14]);
      chk({24'h0, thread_stop_mask}, mdl[8'h18]);
    end
    wr(8'h0c, $urandom);
    rdc(8'h0c);
    wr(8'h0b, $urandom);
    rdc(8'h0b);
    $display("done: register access");
    test_done();
  end
endmodule
